// [verilog/jump_trap_ctrl.sv]
// program-counter control for jumps, linked jumps and trap return, with apb status registers
//
// What this block does
// - trap return resumes at saved address, next instruction is squashed, no delay slot.
// - trap return clears link state so pending conditional store fails.
// - trap return waits for pending control-state writes before fetching target.
// - region target is delay-slot address upper bits, index shifted left two.
// - jumps other than trap return execute delay slot before redirect.
// - region jump in last region word lands in the next region.
// - region jump with link writes register 31 with own address plus 8.
// - register jump with link writes address plus 8, target read first.
// - register jumps load source; with extension, bit 0 sets mode, target cleared.
// - misaligned register target raises address error at fetch, not jump.
// - hint zero is ordinary behaviour; other hints jump the same but also set the hint status event.
module jump_trap_ctrl
    import jump_ctrl_pkg::*;
#(
    parameter int XLEN = 32
)(
    input  wire logic              sys_clk,
    input  wire logic              srst,
    // issue stage
    input  wire logic              issueValid,
    input  wire logic [31:0]       issueInstr,
    input  wire logic [XLEN-1:0]   issuePc,
    input  wire logic [XLEN-1:0]   srcData,
    // control-coprocessor side
    input  wire logic [XLEN-1:0]   resumeAddr,
    input  wire logic              ctrlWritePending,
    // link register write port
    output logic                   linkWe,
    output logic [4:0]             linkIdx,
    output logic [XLEN-1:0]        linkData,
    // redirect to fetch
    output logic                   redirectValid,
    output logic [XLEN-1:0]        redirectPc,
    output logic                   fetchAddrError,
    output logic                   squashNext,
    output logic                   stallIssue,
    output logic                   linkClear,
    output logic                   trapReturnDone,
    output logic                   instructionSetModeBit,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irq
);

    // the block's arithmetic assumes a 32-bit program counter
    if (XLEN != 32)
    begin : g_width_check
        $error("jump_trap_ctrl supports XLEN of 32 only");
    end

    typedef struct packed {
        ctrlState_t          state;
        jumpKind_t           kind;
        logic [XLEN-1:0]     pendTarget;
        logic [25:0]         pendIndex;
        logic                isaMode;
        logic                redirect;
        logic [XLEN-1:0]     redirectPc;
        logic                addrErr;
        logic                squash;
        logic                llClear;
        logic                trapDone;
        logic [1:0]          ctrl;
        logic [EV_W-1:0]     status;
        logic [EV_W-1:0]     mask;
        logic [XLEN-1:0]     lastTarget;
        logic [31:0]         rdata;
        logic                slvErr;
    } regs_t;

    regs_t q;
    regs_t d;

    // instruction classification
    function automatic logic isRegionJump(input logic [31:0] ins);
        return ins[31:OPC_LSB] == OP_REGION_JUMP || ins[31:OPC_LSB] == OP_REGION_LINK;
    endfunction

    function automatic logic isRegJump(input logic [31:0] ins);
        return ins[31:OPC_LSB] == OP_SPECIAL
            && (ins[5:0] == FN_REG_JUMP || ins[5:0] == FN_REG_LINK);
    endfunction

    // anything that changes flow and is forbidden inside a delay slot
    function automatic logic isFlowChange(input logic [31:0] ins);
        return isRegionJump(ins) || isRegJump(ins)
            || ins == TRAP_RETURN_OP || ins == DEBUG_RETURN_OP
            || (ins & WAIT_MASK) == WAIT_MATCH
            || ins[31:28] == 4'h1 || ins[31:OPC_LSB] == 6'h01;
    endfunction

    // misaligned instruction address, depending on the compressed extension
    function automatic logic misaligned(input logic [XLEN-1:0] t, input logic ext);
        return ext ? (t[1:0] == 2'b10) : (t[1:0] != 2'b00);
    endfunction

    logic        isTrapRet;
    logic        isLinkRegion;
    logic        isLinkReg;
    logic        extOn;
    logic [4:0]  srcIdx;
    logic [4:0]  dstIdx;
    logic        apbAccess;
    logic [XLEN-1:0] regTarget;
    logic [EV_W-1:0] evNow;

    // decode of the instruction being issued
    assign isTrapRet    = issueValid && issueInstr == TRAP_RETURN_OP;
    assign isLinkRegion = issueValid && issueInstr[31:OPC_LSB] == OP_REGION_LINK;
    assign isLinkReg    = issueValid && isRegJump(issueInstr) && issueInstr[5:0] == FN_REG_LINK;
    assign extOn        = q.ctrl[CTRL_EXT_BIT];
    assign srcIdx       = issueInstr[SRC_LSB+4:SRC_LSB];
    assign dstIdx       = issueInstr[DST_LSB+4:DST_LSB];
    assign apbAccess    = psel && penable;

    // register target with bit 0 stripped when the extension is present
    assign regTarget = extOn ? {q.pendTarget[XLEN-1:1], 1'b0} : q.pendTarget;

    // link write happens in the issue cycle of the jump itself
    always_comb
    begin
        linkWe   = 1'b0;
        linkIdx  = LINK_REG;
        linkData = issuePc + LINK_OFFSET;
        if (q.state == ST_IDLE && isLinkRegion)
        begin
            linkWe  = 1'b1;
            linkIdx = LINK_REG;
        end
        else if (q.state == ST_IDLE && isLinkReg)
        begin
            linkWe  = 1'b1;
            linkIdx = dstIdx;
        end
    end

    // next-state logic for the whole block
    always_comb
    begin
        d          = q;
        d.redirect = 1'b0;
        d.addrErr  = 1'b0;
        d.squash   = 1'b0;
        d.llClear  = 1'b0;
        d.trapDone = 1'b0;
        d.slvErr   = 1'b0;
        d.status   = '0; // only this cycle's events until merged below

        case (q.state)
            ST_IDLE:
            begin
                if (isTrapRet)
                begin
                    // squash the fetched follower at once; it is never a delay slot
                    d.squash  = 1'b1;
                    d.llClear = 1'b1;
                    d.status[EV_TRAP_RET] = 1'b1;
                    if (ctrlWritePending)
                    begin
                        d.state = ST_BARRIER;
                    end
                    else
                    begin
                        d.redirect   = 1'b1;
                        d.redirectPc = resumeAddr;
                        d.trapDone   = 1'b1;
                        d.isaMode    = extOn ? resumeAddr[0] : 1'b0;
                        d.lastTarget = resumeAddr;
                        if (extOn)
                        begin
                            d.redirectPc = {resumeAddr[XLEN-1:1], 1'b0};
                        end
                    end
                end
                else if (issueValid && isRegionJump(issueInstr))
                begin
                    // target waits for the delay-slot address
                    d.kind      = KIND_REGION;
                    d.pendIndex = issueInstr[25:0];
                    d.state     = ST_SLOT;
                end
                else if (issueValid && isRegJump(issueInstr))
                begin
                    // source is captured before the link write can land
                    d.kind       = KIND_REGISTER;
                    d.pendTarget = srcData;
                    d.state      = ST_SLOT;
                    if (issueInstr[HINT_LSB+4:HINT_LSB] != HINT_DEFAULT)
                    begin
                        d.status[EV_HINT] = 1'b1;
                    end
                    if (isLinkReg && srcIdx == dstIdx)
                    begin
                        d.status[EV_SAME_REG] = 1'b1;
                    end
                end
            end

            ST_SLOT:
            begin
                // redirect only once the delay-slot instruction has issued
                if (issueValid)
                begin
                    d.state    = ST_IDLE;
                    d.redirect = 1'b1;
                    if (isFlowChange(issueInstr))
                    begin
                        d.status[EV_SLOT_BAD] = 1'b1;
                    end
                    if (q.kind == KIND_REGION)
                    begin
                        // upper bits from the slot, so the last word crosses regions
                        d.redirectPc = {issuePc[XLEN-1:REGION_LSB], q.pendIndex, 2'b00};
                        d.lastTarget = {issuePc[XLEN-1:REGION_LSB], q.pendIndex, 2'b00};
                    end
                    else
                    begin
                        d.redirectPc = regTarget;
                        d.lastTarget = q.pendTarget;
                        if (extOn)
                        begin
                            d.isaMode = q.pendTarget[0];
                        end
                        // flagged with the target fetch, not with the jump
                        if (misaligned(q.pendTarget, extOn))
                        begin
                            d.addrErr = 1'b1;
                            d.status[EV_ADDR_ERR] = 1'b1;
                        end
                    end
                end
            end

            ST_BARRIER:
            begin
                // hold off the target fetch until control state settles
                if (!ctrlWritePending)
                begin
                    d.state      = ST_IDLE;
                    d.redirect   = 1'b1;
                    d.redirectPc = extOn ? {resumeAddr[XLEN-1:1], 1'b0} : resumeAddr;
                    d.isaMode    = extOn ? resumeAddr[0] : 1'b0;
                    d.trapDone   = 1'b1;
                    d.lastTarget = resumeAddr;
                end
            end

            default:
            begin
                d.state = ST_IDLE;
            end
        endcase

        // sticky merge; events kept apart so a set beats a same-cycle clear
        evNow    = d.status;
        d.status = q.status | evNow;

        // apb writes; write-one-to-clear loses to a same-cycle event
        if (apbAccess && pwrite)
        begin
            if (paddr == REG_CTRL)
            begin
                d.ctrl = pwdata[1:0];
            end
            else if (paddr == REG_STATUS)
            begin
                d.status = (q.status & ~pwdata[EV_W-1:0]) | evNow;
            end
            else if (paddr == REG_MASK)
            begin
                d.mask = pwdata[EV_W-1:0];
            end
            else if (paddr != REG_TARGET && paddr != REG_STATE)
            begin
                d.slvErr = 1'b1;
            end
        end

        // apb reads, registered in the setup cycle
        d.rdata = 32'h00000000;
        if (psel && !penable && !pwrite)
        begin
            if (paddr == REG_CTRL)
            begin
                d.rdata = {30'h00000000, q.ctrl};
            end
            else if (paddr == REG_STATUS)
            begin
                d.rdata = {27'h0000000, q.status};
            end
            else if (paddr == REG_MASK)
            begin
                d.rdata = {27'h0000000, q.mask};
            end
            else if (paddr == REG_TARGET)
            begin
                d.rdata = q.lastTarget;
            end
            else if (paddr == REG_STATE)
            begin
                d.rdata = {29'h00000000, q.isaMode, q.state};
            end
        end
        else if (apbAccess)
        begin
            d.rdata = q.rdata;
        end
        if (apbAccess && !pwrite && paddr > REG_STATE)
        begin
            d.slvErr = 1'b1;
        end
        if (paddr[1:0] != 2'b00 && apbAccess)
        begin
            d.slvErr = 1'b1;
        end
    end

    // single register stage holding all state
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            q            <= '0;
            q.state      <= ST_IDLE;
            q.kind       <= KIND_REGION;
            q.ctrl       <= CTRL_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    // outputs
    assign redirectValid         = q.redirect;
    assign redirectPc            = q.redirectPc;
    assign fetchAddrError        = q.addrErr;
    assign squashNext            = q.squash;
    assign linkClear             = q.llClear;
    assign trapReturnDone        = q.trapDone;
    assign instructionSetModeBit = q.isaMode;
    assign stallIssue            = q.state == ST_BARRIER; // hold issue during barrier
    assign prdata                = q.rdata;
    assign pready                = 1'b1;       // zero wait states
    assign pslverr               = apbAccess && (paddr[1:0] != 2'b00 || paddr > REG_STATE);
    assign irq                   = |(q.status & q.mask);

endmodule

// [verilog/jump_ctrl_pkg.sv]
// constants, register map and types shared by the jump and trap-return control block
package jump_ctrl_pkg;

    // instruction encodings
    localparam logic [5:0]  OP_SPECIAL      = 6'h00;
    localparam logic [5:0]  OP_REGION_JUMP  = 6'h02;
    localparam logic [5:0]  OP_REGION_LINK  = 6'h03;
    localparam logic [5:0]  FN_REG_JUMP     = 6'h08;
    localparam logic [5:0]  FN_REG_LINK     = 6'h09;
    localparam logic [31:0] TRAP_RETURN_OP  = 32'h42000018;
    localparam logic [31:0] DEBUG_RETURN_OP = 32'h4200001f;
    localparam logic [31:0] WAIT_MASK       = 32'hfe00003f;
    localparam logic [31:0] WAIT_MATCH      = 32'h42000020;

    // field positions
    localparam int OPC_LSB     = 26;
    localparam int SRC_LSB     = 21;
    localparam int DST_LSB     = 11;
    localparam int HINT_LSB    = 6;
    localparam int REGION_LSB  = 28;
    localparam int INDEX_SHIFT = 2;

    // link register values and default jump hint
    localparam logic [4:0]  LINK_REG    = 5'h1f;
    localparam logic [31:0] LINK_OFFSET = 32'h00000008;
    localparam logic [4:0]  HINT_DEFAULT = 5'h00;

    // apb register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MASK   = 8'h08;
    localparam logic [7:0] REG_TARGET = 8'h0c;
    localparam logic [7:0] REG_STATE  = 8'h10;

    // ctrl bits
    localparam int CTRL_EXT_BIT = 0;
    localparam logic [1:0] CTRL_RESET = 2'h1;

    // status event bits
    localparam int EV_TRAP_RET  = 0;
    localparam int EV_ADDR_ERR  = 1;
    localparam int EV_HINT      = 2;
    localparam int EV_SLOT_BAD  = 3;
    localparam int EV_SAME_REG  = 4;
    localparam int EV_W         = 5;

    typedef enum logic [1:0] {KIND_REGION, KIND_REGISTER} jumpKind_t;
    typedef enum logic [1:0] {ST_IDLE, ST_SLOT, ST_BARRIER} ctrlState_t;

endpackage

// [test/jump_trap_ctrl_properties.sv]
// concurrent checks on the ports of the jump and trap-return control block
module jump_trap_ctrl_properties
    import jump_ctrl_pkg::*;
#(
    parameter int XLEN = 32
)(
    input wire logic            sys_clk,
    input wire logic            srst,
    input wire logic            issueValid,
    input wire logic [31:0]     issueInstr,
    input wire logic [XLEN-1:0] issuePc,
    input wire logic [XLEN-1:0] resumeAddr,
    input wire logic            ctrlWritePending,
    input wire logic            linkWe,
    input wire logic [4:0]      linkIdx,
    input wire logic [XLEN-1:0] linkData,
    input wire logic            redirectValid,
    input wire logic [XLEN-1:0] redirectPc,
    input wire logic            fetchAddrError,
    input wire logic            squashNext,
    input wire logic            stallIssue,
    input wire logic            linkClear,
    input wire logic            trapReturnDone
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [31:0]     instr1_q;
    logic [31:0]     instr2_q;
    logic [XLEN-1:0] pc1_q;
    logic [XLEN-1:0] resume1_q;
    logic            isTrap;
    logic            isRegion;

    // short issue history; a region target shows two edges after its jump
    always_ff @(posedge sys_clk)
    begin
        instr1_q  <= issueInstr;
        instr2_q  <= instr1_q;
        pc1_q     <= issuePc;
        resume1_q <= resumeAddr;
    end

    // accepted issues only; meaningless for words sitting in a delay slot
    assign isTrap   = issueValid && !stallIssue && issueInstr == TRAP_RETURN_OP;
    assign isRegion = issueValid && !stallIssue && issueInstr[31:26] inside {OP_REGION_JUMP, OP_REGION_LINK};

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    a_link_data: assert property (linkWe |-> linkData == issuePc + LINK_OFFSET)
        else $error("link data is not jump address plus 8");
    a_link_fixed: assert property (linkWe && issueInstr[31:26] == OP_REGION_LINK |-> linkIdx == LINK_REG)
        else $error("region link not to register 31");
    a_link_dest: assert property (linkWe && issueInstr[31:26] == OP_SPECIAL |-> linkIdx == issueInstr[15:11])
        else $error("register link not to destination field");
    a_region_target: assert property (isRegion ##1 issueValid |=> redirectValid && redirectPc == {pc1_q[31:28], instr2_q[25:0], 2'b00})
        else $error("region target wrong or late");
    a_trap_squash: assert property (isTrap |=> squashNext && linkClear)
        else $error("trap return did not squash follower or clear link");
    a_trap_target: assert property (isTrap && !ctrlWritePending |=> redirectValid && redirectPc[31:1] == resume1_q[31:1])
        else $error("trap return target wrong");
    a_barrier_hold: assert property (stallIssue && ctrlWritePending |=> stallIssue && !redirectValid)
        else $error("trap return left barrier early");
    a_barrier_exit: assert property (stallIssue && !ctrlWritePending |=> redirectValid && trapReturnDone)
        else $error("trap return did not leave barrier");
    a_error_fetch: assert property (fetchAddrError |-> redirectValid)
        else $error("address error away from target fetch");
    a_done_redirect: assert property (trapReturnDone |-> redirectValid)
        else $error("return done without redirect");
endmodule

bind jump_trap_ctrl jump_trap_ctrl_properties #(.XLEN(XLEN)) u_props (
    .sys_clk(sys_clk), .srst(srst), .issueValid(issueValid), .issueInstr(issueInstr), .issuePc(issuePc),
    .resumeAddr(resumeAddr), .ctrlWritePending(ctrlWritePending), .linkWe(linkWe), .linkIdx(linkIdx),
    .linkData(linkData), .redirectValid(redirectValid), .redirectPc(redirectPc), .fetchAddrError(fetchAddrError),
    .squashNext(squashNext), .stallIssue(stallIssue), .linkClear(linkClear), .trapReturnDone(trapReturnDone)
);

// [test/jump_trap_ctrl_tb_top.sv]
// self-checking bench for the jump and trap-return control block
module jump_trap_ctrl_tb_top
    import jump_ctrl_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct {logic [31:0] pc; logic err; logic done;} redirect_t;

    logic        sys_clk = 1'b0, srst = 1'b1, issueValid = 1'b0, ctrlWritePending = 1'b0;
    logic [31:0] issueInstr = 32'h0, issuePc = 32'h0, srcData = 32'h0, resumeAddr = 32'h0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, linkData, redirectPc, rdVal, pcR;
    logic        linkWe, redirectValid, fetchAddrError, squashNext, stallIssue, linkClear;
    logic        trapReturnDone, instructionSetModeBit, pready, pslverr, irq, rdErr;
    logic [4:0]  linkIdx, rdR;
    logic [25:0] idx;
    logic [31:0] srcTab [4] = '{32'h00002001, 32'h00004003, 32'h00003002, 32'h00001000};
    logic [31:0] bareTab [3] = '{32'h00005001, 32'h00005002, 32'h00005000};
    int          errors = 0;
    int          cmp_count = 0;
    redirect_t   expQ[$];
    redirect_t   got;

    jump_trap_ctrl #(.XLEN(32)) DUT (
        .sys_clk(sys_clk), .srst(srst), .issueValid(issueValid), .issueInstr(issueInstr), .issuePc(issuePc),
        .srcData(srcData), .resumeAddr(resumeAddr), .ctrlWritePending(ctrlWritePending), .linkWe(linkWe),
        .linkIdx(linkIdx), .linkData(linkData), .redirectValid(redirectValid), .redirectPc(redirectPc),
        .fetchAddrError(fetchAddrError), .squashNext(squashNext), .stallIssue(stallIssue), .linkClear(linkClear),
        .trapReturnDone(trapReturnDone), .instructionSetModeBit(instructionSetModeBit), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq)
    );

    // 25 MHz core clock
    always #20 sys_clk = ~sys_clk;

    task automatic chk(input bit ok, input string msg);
        cmp_count++;
        if (!ok)
        begin
            errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++)
        begin
            @(posedge sys_clk);
            if (pready === 1'b1)
                break;
        end
        if (n == 16)
        begin
            chk(1'b0, "no apb answer");
            final_report();
        end
        rdVal = prdata;
        rdErr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] addr, input logic [31:0] expv, input string msg);
        apb(1'b0, addr, 32'h0);
        chk(rdVal === expv && rdErr === 1'b0, msg);
    endtask

    // jump, then a plain slot word; the redirect expectation is queued first
    task automatic jump(input logic [31:0] instr, pc, src, tgt, input logic err, mode);
        logic lnk;
        lnk = instr[31:26] == OP_REGION_LINK || (instr[31:26] == OP_SPECIAL && instr[5:0] == FN_REG_LINK);
        expQ.push_back('{tgt, err, 1'b0});
        @(posedge sys_clk);
        issueValid <= 1'b1;
        issueInstr <= instr;
        issuePc    <= pc;
        srcData    <= src;
        @(negedge sys_clk);
        chk(linkWe === lnk, "link enable");
        if (lnk)
            chk(linkData === pc + 32'h8 && linkIdx === (instr[31:26] == OP_SPECIAL ? instr[15:11] : 5'd31), "link");
        @(posedge sys_clk);
        issueInstr <= 32'h0; // slot holds a plain word, never a flow change
        issuePc    <= pc + 32'h4;
        srcData    <= $urandom();
        @(posedge sys_clk);
        issueValid <= 1'b0;
        @(negedge sys_clk);
        chk(instructionSetModeBit === mode, "mode bit");
    endtask

    // trap return; a nonzero hold keeps the barrier for one cycle more than that before release, zero skips it
    task automatic trap(input int hold);
        logic [31:0] ra;
        ra = $urandom() & 32'hfffffffc;
        if (hold == 0)
            expQ.push_back('{ra, 1'b0, 1'b1});
        @(posedge sys_clk);
        resumeAddr       <= ra;
        ctrlWritePending <= hold != 0;
        issueValid       <= 1'b1;
        issueInstr       <= TRAP_RETURN_OP;
        @(posedge sys_clk);
        issueValid <= 1'b0;
        @(negedge sys_clk);
        chk(squashNext === 1'b1 && linkClear === 1'b1, "follower not squashed");
        if (hold != 0)
        begin
            chk(stallIssue === 1'b1, "no barrier stall");
            repeat (hold) @(posedge sys_clk);
            expQ.push_back('{ra, 1'b0, 1'b1});
            ctrlWritePending <= 1'b0;
        end
        repeat (2) @(posedge sys_clk);
    endtask

    // every redirect must match the oldest queued expectation
    always @(negedge sys_clk)
    begin
        if (!srst && redirectValid === 1'b1)
        begin
            if (expQ.size() == 0)
                chk(1'b0, "unexpected redirect");
            else
            begin
                got = expQ.pop_front();
                chk(redirectPc === got.pc && fetchAddrError === got.err && trapReturnDone === got.done, "redirect");
            end
        end
    end

    initial
    begin
        void'($urandom(69396));
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        rchk(REG_CTRL, 32'h1, "ctrl reset");
        rchk(REG_STATUS, 32'h0, "status reset");
        apb(1'b0, 8'h14, 32'h0);
        chk(rdErr === 1'b1, "unmapped read accepted");
        apb(1'b1, 8'h06, 32'h0);
        chk(rdErr === 1'b1, "unaligned write accepted");
        // top word of a region jumps into the next region
        jump({OP_REGION_JUMP, 26'h0000010}, 32'h0ffffffc, 32'h0, 32'h10000040, 1'b0, 1'b0);
        for (int k = 0; k < 6; k++)
        begin
            pcR = $urandom() & 32'hfffffffc;
            idx = 26'($urandom());
            jump({k % 2 ? OP_REGION_LINK : OP_REGION_JUMP, idx}, pcR, $urandom(), {pcR[31:28] + 4'(pcR[27:2] == '1), idx, 2'b00}, 1'b0, 1'b0);
        end
        // register jumps with the extension; the last one carries a nonzero hint
        foreach (srcTab[i])
        begin
            rdR = 5'd5 + 5'($urandom_range(26)); // never the source register 4
            pcR = $urandom() & 32'hfffffffc;
            jump({OP_SPECIAL, 5'd4, 5'd0, i % 2 ? rdR : 5'd0, i == 3 ? 5'h3 : HINT_DEFAULT, i % 2 ? FN_REG_LINK : FN_REG_JUMP}, pcR, srcTab[i], {srcTab[i][31:1], 1'b0}, srcTab[i][1:0] == 2'b10, srcTab[i][0]);
        end
        // without the extension either low bit faults and the target is untouched
        apb(1'b1, REG_CTRL, 32'h0);
        foreach (bareTab[i])
            jump({OP_SPECIAL, 5'd4, 15'h0, FN_REG_JUMP}, 32'h00000100, bareTab[i], bareTab[i], bareTab[i][1:0] != 2'b00, 1'b0);
        apb(1'b1, REG_CTRL, 32'h1);
        trap(0); // issued from idle, never in a slot
        trap(3);
        // sticky events, masking and write-one-to-clear
        rchk(REG_STATUS, 32'h7, "status events");
        chk(irq === 1'b0, "irq while masked");
        apb(1'b1, REG_MASK, 32'h1);
        for (int n = 0; n < 8 && irq !== 1'b1; n++)
            @(negedge sys_clk);
        chk(irq === 1'b1, "irq not raised");
        apb(1'b1, REG_STATUS, 32'h1);
        for (int n = 0; n < 8 && irq !== 1'b0; n++)
            @(negedge sys_clk);
        chk(irq === 1'b0, "irq not cleared");
        rchk(REG_STATUS, 32'h6, "status after clear");
        repeat (4) @(posedge sys_clk);
        chk(expQ.size() == 0, "redirect missing");
        final_report();
    end
endmodule
